// File: hw/ssm_core.sv
// startup sequencer, angle lead, dead-time compensation and modulation for a sensorless drive
// assumes angle, speed and currents are sampled estimates synchronous to CLK
`timescale 1ns/1ps

// Overview of operation
// - startup injects larger pulse into d command
// - wait settle time before convergence checking
// - ten successive one-degree steps mean converged
// - no convergence by window end flags error
// - polarity integration runs during convergence window
// - integral magnitude below ten flags polarity error
// - rising through switch speed halves injection, observer
// - falling through switch speed restarts injection
// - switching speed is a software register
// - transform uses angle advanced half interval
// - advance interpolated from previous interval change
// - add inverse dead-time error per current
// - selectable sine or space-vector modulation
// - sine rate is command over bus voltage
// - subtract max/min mean from all phases
// - space-vector rate from offset command over bus
// - pulse alternates sign, quarter carrier period
// - negative integral north, positive south
module ssm_core
  import ssm_pkg::*;
#(
  parameter int unsigned SETTLE_CYCLES = SETTLE_CYC,
  parameter int unsigned WINDOW_CYCLES = CONV_WINDOW_CYC,
  parameter int unsigned CTRL_CYCLES = CTRL_CYC
) (
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic [7:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [31:0] REG_RDATA,
  input wire logic [15:0] ANGLE_EST,
  input wire logic signed [15:0] SPEED_EST,
  input wire logic signed [15:0] POL_RESP,
  input wire ssm_dq_t V_DQ_CMD,
  input wire ssm_phase_t I_PHASE,
  input wire logic [15:0] BUS_VOLT,
  output ssm_phase_t DUTY,
  output logic signed [15:0] MOD_RATE,
  output logic signed [15:0] VD_INJECTED,
  output logic ALGO_HIGH,
  output logic RUNNING,
  output logic POS_ERR,
  output logic POL_ERR,
  output logic POLARITY_N
);

  // ****************************************************************
  // declarations
  // ****************************************************************
  logic [31:0] rdata_ff, nxt_rdata;
  logic start_ff, nxt_start;
  ssm_mod_mode_t mode_ff, nxt_mode;
  logic [15:0] startup_amp_ff, nxt_startup_amp, run_amp_ff, nxt_run_amp;
  logic [15:0] switch_speed_ff, nxt_switch_speed;
  logic [15:0] dt_volt_ff, nxt_dt_volt, dt_thr_ff, nxt_dt_thr;
  ssm_state_t state_ff, nxt_state;
  logic [31:0] timer_ff, nxt_timer;
  logic [15:0] tick_cnt_ff, nxt_tick_cnt, pulse_cnt_ff, nxt_pulse_cnt;
  logic pulse_pos_ff, nxt_pulse_pos;
  logic [3:0] conv_cnt_ff, nxt_conv_cnt, seq_cnt_ff, nxt_seq_cnt;
  logic converged_ff, nxt_converged, pos_err_ff, nxt_pos_err;
  logic pol_err_ff, nxt_pol_err, pol_n_ff, nxt_pol_n;
  logic signed [31:0] polarity_integral_ff, nxt_polarity_integral;
  logic [15:0] ang_prev_ff, nxt_ang_prev, ang_delta_ff, nxt_ang_delta;
  ssm_phase_t duty_ff, nxt_duty;
  logic signed [15:0] mod_rate_ff, nxt_mod_rate, vd_inj_ff, nxt_vd_inj;
  logic tick, in_tol, fast;
  logic [15:0] ang_step, adv_angle, inj_amp;
  logic signed [15:0] vd_tot, sin_a, cos_a, v_alpha, v_beta, sb, half_a, vmax, vmin;
  logic signed [16:0] off_sum;
  logic signed [31:0] integ_sum;
  ssm_phase_t ph, ph_dt, ph_mod;

  // ****************************************************************
  // register port
  // ****************************************************************
  always_comb begin
    nxt_start = start_ff;
    nxt_mode = mode_ff;
    nxt_startup_amp = startup_amp_ff;
    nxt_run_amp = run_amp_ff;
    nxt_switch_speed = switch_speed_ff;
    nxt_dt_volt = dt_volt_ff;
    nxt_dt_thr = dt_thr_ff;
    nxt_rdata = 32'h00000000;
    if (REG_WR) begin
      case (REG_ADDR)
        ADDR_CTRL: begin
          nxt_start = REG_WDATA[CTRL_START_BIT];
          nxt_mode = ssm_mod_mode_t'(REG_WDATA[CTRL_MODE_BIT]);
        end
        ADDR_STARTUP_AMP: nxt_startup_amp = REG_WDATA[15:0];
        ADDR_RUN_AMP: nxt_run_amp = REG_WDATA[15:0];
        ADDR_SWITCH_SPEED: nxt_switch_speed = REG_WDATA[15:0];
        ADDR_DT_VOLT: nxt_dt_volt = REG_WDATA[15:0];
        ADDR_DT_THR: nxt_dt_thr = REG_WDATA[15:0];
        default: nxt_start = start_ff;
      endcase
    end
    if (REG_RD) begin
      case (REG_ADDR)
        ADDR_CTRL: begin
          nxt_rdata[CTRL_START_BIT] = start_ff;
          nxt_rdata[CTRL_MODE_BIT] = mode_ff;
        end
        ADDR_STARTUP_AMP: nxt_rdata[15:0] = startup_amp_ff;
        ADDR_RUN_AMP: nxt_rdata[15:0] = run_amp_ff;
        ADDR_SWITCH_SPEED: nxt_rdata[15:0] = switch_speed_ff;
        ADDR_DT_VOLT: nxt_rdata[15:0] = dt_volt_ff;
        ADDR_DT_THR: nxt_rdata[15:0] = dt_thr_ff;
        ADDR_STATUS: begin
          nxt_rdata[2:0] = state_ff;
          nxt_rdata[ST_CONV_BIT] = converged_ff;
          nxt_rdata[ST_POSERR_BIT] = pos_err_ff;
          nxt_rdata[ST_POLERR_BIT] = pol_err_ff;
          nxt_rdata[ST_POLN_BIT] = pol_n_ff;
          nxt_rdata[ST_HIGH_BIT] = ALGO_HIGH;
        end
        default: nxt_rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rdata_ff <= 32'h00000000;
      start_ff <= 1'b0;
      mode_ff <= SINE_MODULATION_MODE;
      startup_amp_ff <= STARTUP_AMP_RST;
      run_amp_ff <= RUN_AMP_RST;
      switch_speed_ff <= SWITCH_SPEED_RST;
      dt_volt_ff <= DT_VOLT_RST;
      dt_thr_ff <= DT_THR_RST;
    end else begin
      rdata_ff <= nxt_rdata;
      start_ff <= nxt_start;
      mode_ff <= nxt_mode;
      startup_amp_ff <= nxt_startup_amp;
      run_amp_ff <= nxt_run_amp;
      switch_speed_ff <= nxt_switch_speed;
      dt_volt_ff <= nxt_dt_volt;
      dt_thr_ff <= nxt_dt_thr;
    end
  end

  // ****************************************************************
  // startup and speed-range sequencer
  // ****************************************************************
  assign tick = (tick_cnt_ff == 16'(CTRL_CYCLES - 1));
  assign ang_step = ANGLE_EST - ang_prev_ff;
  assign in_tol = (ssm_abs(ang_step) <= ANGLE_TOL);
  assign fast = (ssm_abs(SPEED_EST) >= switch_speed_ff);
  assign integ_sum = polarity_integral_ff + 32'(POL_RESP);

  always_comb begin
    nxt_state = state_ff;
    nxt_timer = timer_ff + 32'h00000001;
    nxt_tick_cnt = tick ? 16'h0000 : tick_cnt_ff + 16'h0001;
    nxt_pulse_cnt = pulse_cnt_ff + 16'h0001;
    nxt_pulse_pos = pulse_pos_ff;
    nxt_conv_cnt = conv_cnt_ff;
    nxt_seq_cnt = seq_cnt_ff;
    nxt_converged = converged_ff;
    nxt_pos_err = pos_err_ff;
    nxt_pol_err = pol_err_ff;
    nxt_pol_n = pol_n_ff;
    nxt_polarity_integral = polarity_integral_ff;
    nxt_ang_prev = tick ? ANGLE_EST : ang_prev_ff;
    nxt_ang_delta = tick ? ang_step : ang_delta_ff;
    if (pulse_cnt_ff == 16'(PULSE_HALF_CYC - 1)) begin
      nxt_pulse_cnt = 16'h0000;
      nxt_pulse_pos = !pulse_pos_ff;
    end
    if (tick && seq_cnt_ff != SEQ_TICKS) begin
      nxt_seq_cnt = seq_cnt_ff + 4'h1;
    end
    case (state_ff)
      ST_IDLE: begin
        if (start_ff) begin
          nxt_state = ST_SETTLE;
          nxt_timer = 32'h00000000;
          nxt_converged = 1'b0;
          nxt_pos_err = 1'b0;
          nxt_pol_err = 1'b0;
          nxt_polarity_integral = 32'sh00000000;
        end
      end
      ST_SETTLE: begin
        if (timer_ff == 32'(SETTLE_CYCLES - 1)) begin
          nxt_state = ST_CONVERGE;
          nxt_timer = 32'h00000000;
          nxt_conv_cnt = 4'h0;
        end
      end
      ST_CONVERGE: begin
        if (tick) begin
          nxt_polarity_integral = integ_sum;
          if (!in_tol) begin
            nxt_conv_cnt = 4'h0;
          end else if (conv_cnt_ff != CONV_NEEDED) begin
            nxt_conv_cnt = conv_cnt_ff + 4'h1;
          end
          if (in_tol && conv_cnt_ff == CONV_NEEDED - 4'h1) begin
            nxt_converged = 1'b1;
          end
        end
        if (timer_ff == 32'(WINDOW_CYCLES - 1)) begin
          nxt_pos_err = !nxt_converged;
          nxt_pol_err = (nxt_polarity_integral < POL_MIN) &&
                        (nxt_polarity_integral > -POL_MIN);
          nxt_pol_n = nxt_polarity_integral[31];
          nxt_state = (nxt_converged && !nxt_pol_err) ? ST_RUN_LOW : ST_ERROR;
        end
      end
      ST_ERROR: begin
        if (!start_ff) begin
          nxt_state = ST_IDLE;
        end
      end
      ST_RUN_LOW: begin
        if (!start_ff) begin
          nxt_state = ST_IDLE;
        end else if (fast) begin
          nxt_state = ST_HALVE;
          nxt_seq_cnt = 4'h0;
        end
      end
      ST_HALVE: begin
        if (seq_cnt_ff == SEQ_TICKS) begin
          nxt_state = ST_RUN_HIGH;
        end
      end
      ST_RUN_HIGH: begin
        if (!start_ff) begin
          nxt_state = ST_IDLE;
        end else if (!fast) begin
          nxt_state = ST_RESTART;
          nxt_seq_cnt = 4'h0;
        end
      end
      ST_RESTART: begin
        if (seq_cnt_ff == SEQ_TICKS) begin
          nxt_state = ST_RUN_LOW;
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state_ff <= ST_IDLE;
      timer_ff <= 32'h00000000;
      tick_cnt_ff <= 16'h0000;
      pulse_cnt_ff <= 16'h0000;
      pulse_pos_ff <= 1'b0;
      conv_cnt_ff <= 4'h0;
      seq_cnt_ff <= 4'h0;
      converged_ff <= 1'b0;
      pos_err_ff <= 1'b0;
      pol_err_ff <= 1'b0;
      pol_n_ff <= 1'b0;
      polarity_integral_ff <= 32'sh00000000;
      ang_prev_ff <= 16'h0000;
      ang_delta_ff <= 16'h0000;
    end else begin
      state_ff <= nxt_state;
      timer_ff <= nxt_timer;
      tick_cnt_ff <= nxt_tick_cnt;
      pulse_cnt_ff <= nxt_pulse_cnt;
      pulse_pos_ff <= nxt_pulse_pos;
      conv_cnt_ff <= nxt_conv_cnt;
      seq_cnt_ff <= nxt_seq_cnt;
      converged_ff <= nxt_converged;
      pos_err_ff <= nxt_pos_err;
      pol_err_ff <= nxt_pol_err;
      pol_n_ff <= nxt_pol_n;
      polarity_integral_ff <= nxt_polarity_integral;
      ang_prev_ff <= nxt_ang_prev;
      ang_delta_ff <= nxt_ang_delta;
    end
  end

  // ****************************************************************
  // voltage datapath
  // ****************************************************************
  always_comb begin
    case (state_ff)
      ST_SETTLE, ST_CONVERGE: inj_amp = startup_amp_ff;
      ST_RUN_LOW: inj_amp = run_amp_ff;
      ST_HALVE, ST_RESTART: inj_amp = run_amp_ff >> 1;
      default: inj_amp = 16'h0000;
    endcase
  end

  assign vd_tot = V_DQ_CMD.d_axis_voltage_command +
                  (pulse_pos_ff ? $signed(inj_amp) : -$signed(inj_amp));
  // half the last interval's step, sign kept so reverse rotation leads too
  assign adv_angle = ANGLE_EST + 16'($signed(ang_delta_ff) >>> 1);
  assign sin_a = ssm_sin(adv_angle);
  assign cos_a = ssm_sin(adv_angle + 16'h4000);
  assign v_alpha = ssm_mulq(vd_tot, cos_a) - ssm_mulq(V_DQ_CMD.q_axis_voltage_command, sin_a);
  assign v_beta = ssm_mulq(vd_tot, sin_a) + ssm_mulq(V_DQ_CMD.q_axis_voltage_command, cos_a);
  assign sb = ssm_mulq(v_beta, SQRT3_HALF_Q15);
  assign half_a = v_alpha >>> 1;

  // below the threshold only half the error is assumed: the error ramps near zero
  function automatic logic signed [15:0] dt_comp(input logic signed [15:0] i);
    logic signed [15:0] mag;
    mag = (ssm_abs(i) >= dt_thr_ff) ? $signed(dt_volt_ff) : $signed(dt_volt_ff >> 1);
    return i[15] ? 16'(-mag) : mag;
  endfunction : dt_comp

  always_comb begin
    ph.u = v_alpha;
    ph.v = sb - half_a;
    ph.w = -sb - half_a;
    ph_dt.u = ph.u + dt_comp(I_PHASE.u);
    ph_dt.v = ph.v + dt_comp(I_PHASE.v);
    ph_dt.w = ph.w + dt_comp(I_PHASE.w);
    vmax = ph_dt.u;
    vmin = ph_dt.u;
    if (ph_dt.v > vmax) vmax = ph_dt.v;
    if (ph_dt.w > vmax) vmax = ph_dt.w;
    if (ph_dt.v < vmin) vmin = ph_dt.v;
    if (ph_dt.w < vmin) vmin = ph_dt.w;
    off_sum = (17'(vmax) + 17'(vmin)) >>> 1;
    ph_mod = ph_dt;
    if (mode_ff == SPACE_VECTOR_MODULATION_MODE) begin
      ph_mod.u = ph_dt.u - off_sum[15:0];
      ph_mod.v = ph_dt.v - off_sum[15:0];
      ph_mod.w = ph_dt.w - off_sum[15:0];
    end
    nxt_duty = duty_ff;
    nxt_mod_rate = mod_rate_ff;
    nxt_vd_inj = vd_tot;
    if (tick) begin
      nxt_duty.u = ssm_rate(ph_mod.u, BUS_VOLT);
      nxt_duty.v = ssm_rate(ph_mod.v, BUS_VOLT);
      nxt_duty.w = ssm_rate(ph_mod.w, BUS_VOLT);
      nxt_mod_rate = ssm_rate(ph_mod.u, BUS_VOLT);
      if (ssm_abs(ph_mod.v) > ssm_abs(ph_mod.u)) begin
        nxt_mod_rate = ssm_rate(ph_mod.v, BUS_VOLT);
      end
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      duty_ff <= '0;
      mod_rate_ff <= 16'sh0000;
      vd_inj_ff <= 16'sh0000;
    end else begin
      duty_ff <= nxt_duty;
      mod_rate_ff <= nxt_mod_rate;
      vd_inj_ff <= nxt_vd_inj;
    end
  end

  assign REG_RDATA = rdata_ff;
  assign DUTY = duty_ff;
  assign MOD_RATE = mod_rate_ff;
  assign VD_INJECTED = vd_inj_ff;
  assign ALGO_HIGH = (state_ff == ST_HALVE) || (state_ff == ST_RUN_HIGH);
  assign RUNNING = state_ff[2];
  assign POS_ERR = pos_err_ff;
  assign POL_ERR = pol_err_ff;
  assign POLARITY_N = pol_n_ff;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!ARST_N);

  a_settle_hold: assert property ((state_ff == ST_SETTLE && timer_ff < 32'(SETTLE_CYCLES - 1))
    |=> state_ff != ST_CONVERGE) else $error("convergence began before settling");
  a_conv_flag: assert property ((state_ff == ST_CONVERGE && tick && in_tol &&
    conv_cnt_ff == 4'h9) |=> converged_ff) else $error("tenth step not converged");
  a_conv_reset: assert property ((state_ff == ST_CONVERGE && tick && !in_tol)
    |=> conv_cnt_ff == 4'h0) else $error("streak not cleared");
  a_pos_error: assert property ((state_ff == ST_CONVERGE && timer_ff == 32'(WINDOW_CYCLES - 1)
    && !converged_ff && !(tick && in_tol && conv_cnt_ff == 4'h9))
    |=> pos_err_ff && state_ff == ST_ERROR) else $error("missing position error");
  a_pol_error: assert property ($rose(pol_err_ff) |-> polarity_integral_ff < POL_MIN
    && polarity_integral_ff > -POL_MIN) else $error("bad polarity error");
  a_pol_north: assert property ($rose(state_ff == ST_RUN_LOW) && $past(state_ff) == ST_CONVERGE
    |-> pol_n_ff == polarity_integral_ff[31]) else $error("polarity sign wrong");
  a_run_gate: assert property ($rose(state_ff == ST_RUN_LOW) && $past(state_ff) == ST_CONVERGE
    |-> converged_ff && !pol_err_ff && !pos_err_ff) else $error("ran unconverged");
  a_halve_amp: assert property (state_ff == ST_HALVE |-> inj_amp == (run_amp_ff >> 1)
    && ALGO_HIGH) else $error("injection not halved");
  a_high_noinj: assert property (state_ff == ST_RUN_HIGH |-> vd_tot ==
    V_DQ_CMD.d_axis_voltage_command) else $error("injection in high range");
  a_speed_down: assert property (state_ff == ST_RUN_HIGH && start_ff && !fast
    |=> state_ff == ST_RESTART ##1 inj_amp == (run_amp_ff >> 1))
    else $error("injection not restarted");
  a_pulse_flip: assert property (pulse_cnt_ff == 16'(PULSE_HALF_CYC - 1)
    |=> pulse_pos_ff != $past(pulse_pos_ff)) else $error("pulse did not alternate");

  c_run_low: cover property ($rose(state_ff == ST_RUN_LOW));
  c_run_high: cover property ($rose(state_ff == ST_RUN_HIGH));
  c_error: cover property ($rose(state_ff == ST_ERROR));
  c_svm: cover property (tick && mode_ff == SPACE_VECTOR_MODULATION_MODE && RUNNING);

endmodule : ssm_core

// File: hw/ssm_pkg.sv
// constants, types and helper arithmetic for the sensorless startup and modulation core
// assumes a single 200 MHz clock and signed Q15 voltages, angles as 16-bit fractions of a turn
package ssm_pkg;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int unsigned CLK_FREQ_HZ = 200_000_000;
  localparam int unsigned SETTLE_TIME_MS = 200;
  localparam int unsigned SETTLE_CYC = SETTLE_TIME_MS * (CLK_FREQ_HZ / 1000);
  localparam int unsigned CONV_WINDOW_MS = 100;
  localparam int unsigned CONV_WINDOW_CYC = CONV_WINDOW_MS * (CLK_FREQ_HZ / 1000);
  localparam int unsigned CTRL_PERIOD_US = 50;
  localparam int unsigned CTRL_CYC = CTRL_PERIOD_US * (CLK_FREQ_HZ / 1_000_000);
  localparam int unsigned CARRIER_PERIOD_US = 50;
  // pulse period is a quarter carrier, inside the half..eighth range
  localparam int unsigned PULSE_DIV = 4;
  localparam int unsigned PULSE_HALF_CYC =
    CARRIER_PERIOD_US * (CLK_FREQ_HZ / 1_000_000) / (2 * PULSE_DIV);
  localparam logic [3:0] SEQ_TICKS = 4'h8;

  // ****************************************************************
  // thresholds
  // ****************************************************************
  // one degree of a 65536-count turn, rounded down
  localparam logic [15:0] ANGLE_TOL = 16'h00B6;
  localparam logic [3:0] CONV_NEEDED = 4'hA;
  localparam logic signed [31:0] POL_MIN = 32'sh0000000A;
  localparam logic signed [15:0] SQRT3_HALF_Q15 = 16'sh6ED9;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STARTUP_AMP = 8'h04;
  localparam logic [7:0] ADDR_RUN_AMP = 8'h08;
  localparam logic [7:0] ADDR_SWITCH_SPEED = 8'h0C;
  localparam logic [7:0] ADDR_DT_VOLT = 8'h10;
  localparam logic [7:0] ADDR_DT_THR = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_MODE_BIT = 1;
  localparam int ST_CONV_BIT = 3;
  localparam int ST_POSERR_BIT = 4;
  localparam int ST_POLERR_BIT = 5;
  localparam int ST_POLN_BIT = 6;
  localparam int ST_HIGH_BIT = 7;
  localparam logic [15:0] STARTUP_AMP_RST = 16'h1000;
  localparam logic [15:0] RUN_AMP_RST = 16'h0400;
  localparam logic [15:0] SWITCH_SPEED_RST = 16'h012C;
  localparam logic [15:0] DT_VOLT_RST = 16'h0100;
  localparam logic [15:0] DT_THR_RST = 16'h0080;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic {
    SINE_MODULATION_MODE = 1'b0,
    SPACE_VECTOR_MODULATION_MODE = 1'b1
  } ssm_mod_mode_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SETTLE = 3'b001,
    ST_CONVERGE = 3'b010,
    ST_ERROR = 3'b011,
    ST_RUN_LOW = 3'b100,
    ST_HALVE = 3'b101,
    ST_RUN_HIGH = 3'b110,
    ST_RESTART = 3'b111
  } ssm_state_t;

  typedef struct packed {
    logic signed [15:0] u;
    logic signed [15:0] v;
    logic signed [15:0] w;
  } ssm_phase_t;

  typedef struct packed {
    logic signed [15:0] d_axis_voltage_command;
    logic signed [15:0] q_axis_voltage_command;
  } ssm_dq_t;

  // ****************************************************************
  // arithmetic
  // ****************************************************************
  function automatic logic [15:0] ssm_abs(input logic signed [15:0] x);
    return x[15] ? 16'(-x) : 16'(x);
  endfunction : ssm_abs

  function automatic logic signed [15:0] ssm_mulq(input logic signed [15:0] a,
                                                  input logic signed [15:0] b);
    logic signed [31:0] pr;
    pr = a * b;
    return pr[30:15];
  endfunction : ssm_mulq

  // parabolic sine, cheap and within a few percent
  function automatic logic signed [15:0] ssm_sin(input logic [15:0] ang);
    logic [31:0] p;
    logic [31:0] prod;
    logic signed [15:0] mag;
    p = {17'h00000, ang[14:0]};
    prod = (p * (32'h00008000 - p)) >> 13;
    mag = (prod > 32'h00007FFF) ? 16'sh7FFF : $signed(prod[15:0]);
    return ang[15] ? 16'(-mag) : mag;
  endfunction : ssm_sin

  function automatic logic signed [15:0] ssm_rate(input logic signed [15:0] v,
                                                  input logic [15:0] e);
    logic signed [31:0] num;
    logic signed [31:0] q;
    num = {{1{v[15]}}, v, 15'h0000};
    q = (e == 16'h0000) ? 32'sh00000000 : num / $signed({16'h0000, e});
    if (q > 32'sh00007FFF) begin
      q = 32'sh00007FFF;
    end else if (q < -32'sh00007FFF) begin
      q = -32'sh00007FFF;
    end
    return q[15:0];
  endfunction : ssm_rate

endpackage : ssm_pkg

// File: verif/ssm_core_tb.sv
// self-checking bench for ssm_core with shortened startup counts
// assumes ssm_pkg and ssm_motor_model; angle estimate is a ramp made here
`timescale 1ns/1ps
module ssm_core_tb;
  import ssm_pkg::*;
  localparam int SET_C = 2000;
  localparam int WIN_C = 2000;
  logic CLK = 1'b0;
  logic ARST_N = 1'b0;
  logic [7:0] REG_ADDR = 8'h00;
  logic [31:0] REG_WDATA = 32'h00000000;
  logic REG_WR = 1'b0;
  logic REG_RD = 1'b0;
  logic [31:0] REG_RDATA;
  logic [15:0] ANGLE_EST = 16'h0000;
  logic [15:0] ang_step = 16'h0000;
  logic signed [15:0] SPEED_EST = 16'sh0000;
  logic signed [15:0] POL_RESP = 16'sh0000;
  ssm_dq_t V_DQ_CMD = '0;
  ssm_phase_t I_PHASE;
  logic [15:0] BUS_VOLT = 16'h7000;
  ssm_phase_t DUTY;
  logic signed [15:0] MOD_RATE;
  logic signed [15:0] VD_INJECTED;
  logic ALGO_HIGH, RUNNING, POS_ERR, POL_ERR, POLARITY_N;
  int errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  always #2.5 CLK = ~CLK;
  always @(posedge CLK) begin
    ANGLE_EST <= ANGLE_EST + ang_step;
    cyc <= cyc + 1;
  end
  ssm_core #(.SETTLE_CYCLES(SET_C), .WINDOW_CYCLES(WIN_C), .CTRL_CYCLES(20)) ssm_core_inst (
    .CLK(CLK), .ARST_N(ARST_N), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
    .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .ANGLE_EST(ANGLE_EST), .SPEED_EST(SPEED_EST),
    .POL_RESP(POL_RESP), .V_DQ_CMD(V_DQ_CMD), .I_PHASE(I_PHASE), .BUS_VOLT(BUS_VOLT),
    .DUTY(DUTY), .MOD_RATE(MOD_RATE), .VD_INJECTED(VD_INJECTED), .ALGO_HIGH(ALGO_HIGH),
    .RUNNING(RUNNING), .POS_ERR(POS_ERR), .POL_ERR(POL_ERR), .POLARITY_N(POLARITY_N));
  ssm_motor_model ssm_motor_model_inst (.CLK(CLK), .ARST_N(ARST_N), .DUTY(DUTY),
    .I_PHASE(I_PHASE));
  // ****************************************************************
  // shared tasks
  // ****************************************************************
  function automatic logic [15:0] mag(input logic signed [15:0] x);
    return x[15] ? 16'(-x) : 16'(x);
  endfunction : mag
  task automatic test_done();
    if (errors == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : test_done
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK);
    REG_WR <= 1'b1;
    REG_ADDR <= a;
    REG_WDATA <= d;
    @(posedge CLK);
    REG_WR <= 1'b0;
  endtask : wr
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge CLK);
    REG_RD <= 1'b1;
    REG_ADDR <= a;
    @(posedge CLK);
    REG_RD <= 1'b0;
    #1 d = REG_RDATA;
  endtask : rd
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_regs();
    logic [31:0] d;
    logic [7:0] a [6] = '{ADDR_STARTUP_AMP, ADDR_RUN_AMP, ADDR_SWITCH_SPEED, ADDR_DT_VOLT,
                          ADDR_DT_THR, 8'h1C};
    logic [15:0] e [6] = '{STARTUP_AMP_RST, RUN_AMP_RST, SWITCH_SPEED_RST, DT_VOLT_RST,
                           DT_THR_RST, 16'h0000};
    for (int i = 0; i < 6; i++) begin
      rd(a[i], d);
      chk(d, {16'h0000, e[i]}, "reg reset");
    end
    wr(ADDR_STATUS, 32'h000000FF);
    rd(ADDR_STATUS, d);
    chk(d, 32'h00000000, "status read only");
    wr(ADDR_SWITCH_SPEED, 32'h00000100);
    rd(ADDR_SWITCH_SPEED, d);
    chk(d, 32'h00000100, "switch speed");
  endtask : t_regs
  // 9 counts a cycle is 180 a tick, inside tolerance; 10 gives 200, outside
  task automatic t_start(input logic [15:0] step, input logic signed [15:0] resp, input logic ok);
    logic [31:0] d;
    logic signed [15:0] v0;
    int t0;
    @(posedge CLK);
    ang_step <= step;
    POL_RESP <= resp;
    t0 = cyc;
    wr(ADDR_CTRL, 32'h00000003);
    while (cyc < t0 + SET_C - 20) @(posedge CLK);
    rd(ADDR_STATUS, d);
    chk(d[2:0], 32'(ST_SETTLE), "settling");
    v0 = VD_INJECTED;
    chk(mag(v0), STARTUP_AMP_RST, "startup pulse");
    repeat (1250) @(posedge CLK);
    #1 chk(VD_INJECTED, 16'(-v0), "pulse sign");
    rd(ADDR_STATUS, d);
    chk(d[2:0], 32'(ST_CONVERGE), "converging");
    while (cyc < t0 + SET_C + WIN_C - 20) @(posedge CLK);
    #1 chk(RUNNING, 1'b0, "early decision");
    while (cyc < t0 + SET_C + WIN_C + 20) @(posedge CLK);
    #1 chk(RUNNING, ok, "running");
    chk(POS_ERR, !ok, "position error");
    chk(POL_ERR, !ok, "polarity error");
    if (ok) chk(POLARITY_N, 1'b1, "north");
  endtask : t_start
  task automatic t_speed();
    int n, mx, mn;
    logic [15:0] m;
    chk(mag(VD_INJECTED), RUN_AMP_RST, "run pulse");
    @(posedge CLK);
    SPEED_EST <= 16'sh0100;
    V_DQ_CMD.q_axis_voltage_command <= 16'sh2000;
    n = 0;
    while (ALGO_HIGH !== 1'b1 && n < 100) begin
      @(posedge CLK);
      n++;
    end
    repeat (3) @(posedge CLK);
    #1 chk(mag(VD_INJECTED), 16'h0200, "halved pulse");
    repeat (200) @(posedge CLK);
    #1 chk(VD_INJECTED, 16'h0000, "no pulse high");
    chk(ALGO_HIGH, 1'b1, "observer range");
    // offset removal leaves max plus min within rounding of zero
    mx = DUTY.u;
    mn = DUTY.u;
    if (DUTY.v > mx) mx = DUTY.v;
    if (DUTY.w > mx) mx = DUTY.w;
    if (DUTY.v < mn) mn = DUTY.v;
    if (DUTY.w < mn) mn = DUTY.w;
    chk(mx + mn <= 2 && mx + mn >= -2, 1'b1, "space vector centre");
    m = (mag(DUTY.u) > mag(DUTY.v)) ? mag(DUTY.u) : mag(DUTY.v);
    chk(mag(MOD_RATE), m, "modulation rate");
    @(posedge CLK);
    SPEED_EST <= 16'sh00FF;
    n = 0;
    while (ALGO_HIGH !== 1'b0 && n < 100) begin
      @(posedge CLK);
      n++;
    end
    repeat (3) @(posedge CLK);
    #1 chk(mag(VD_INJECTED), 16'h0200, "restart pulse");
    chk(RUNNING, 1'b1, "restart running");
    repeat (200) @(posedge CLK);
    #1 chk(mag(VD_INJECTED), RUN_AMP_RST, "low range pulse");
  endtask : t_speed
  initial begin
    #100000;
    errors++;
    test_done();
  end
  initial begin
    logic [31:0] d;
    repeat (12) @(posedge CLK);
    ARST_N <= 1'b1;
    t_regs();
    t_start(16'h0009, -16'sh0005, 1'b1);
    t_speed();
    wr(ADDR_CTRL, 32'h00000000);
    rd(ADDR_STATUS, d);
    chk(d[2:0], 32'(ST_IDLE), "stop to idle");
    // no command and no pulse: only the half dead-time term reaches the waves
    @(posedge CLK);
    V_DQ_CMD <= '0;
    repeat (120) @(posedge CLK);
    #1 chk(mag(DUTY.u), 32'(DT_VOLT_RST >> 1) * 32'h8000 / BUS_VOLT, "dead time");
    chk(mag(MOD_RATE), 32'(DT_VOLT_RST >> 1) * 32'h8000 / BUS_VOLT, "sine rate");
    t_start(16'h000A, 16'sh0000, 1'b0);
    rd(ADDR_STATUS, d);
    chk(d[2:0], 32'(ST_ERROR), "error held");
    test_done();
  end
endmodule : ssm_core_tb

// File: verif/ssm_motor_model.sv
// inverter and motor stand-in: phase currents follow the modulation waves
// assumes the core's CLK and ARST_N; current is a quarter of duty, one cycle late
`timescale 1ns/1ps
module ssm_motor_model
  import ssm_pkg::*;
(
  input wire logic CLK,
  input wire logic ARST_N,
  input wire ssm_phase_t DUTY,
  output ssm_phase_t I_PHASE
);
  // winding lag kept to one cycle, enough to give dead-time comp a current sign
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      I_PHASE <= '0;
    end else begin
      I_PHASE.u <= DUTY.u >>> 2;
      I_PHASE.v <= DUTY.v >>> 2;
      I_PHASE.w <= DUTY.w >>> 2;
    end
  end
endmodule : ssm_motor_model
